// *** rtl/wrhc_core.sv ***
/*
 * Receiver control core: power-link start-up, control inputs, customer
 * byte channel and an AXI4-Lite register slave.
 * Assumes the power-link modulator acknowledges each message on clk and
 * that pwr_sig, oc_det and the host pins are asynchronous to clk.
 */
`timescale 1ns/10ps
module wrhc_core #(
    parameter int unsigned SLOT_CYC = wrhc_pkg::SLOT_CYC,
    parameter int unsigned PAUSE_CYC = wrhc_pkg::PAUSE_CYC
) (
    // System
    input wire logic clk,
    input wire logic reset_n,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Host pins
    input wire logic tcut_n,
    input wire logic charged_n,
    input wire logic spi_clk,
    input wire logic spi_rx,
    output logic comms_flag_q,
    // Power link
    input wire logic pwr_sig,
    input wire logic oc_det,
    output wrhc_pkg::wrhc_msg_t msg_q,
    output logic msg_valid_q,
    input wire logic msg_ack,
    output logic out_en_q,
    output logic [3:0] err_code_q
);
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic pwr_s;
    logic oc_s;
    logic tcut_s_n;
    logic charged_s_n;
    wrhc_pkg::wrhc_state_t state_q;
    logic [31:0] slot_cnt_q;
    logic [31:0] pause_cnt_q;
    logic [1:0] retry_q;
    logic [31:0] ctrl_q;
    logic lock_clr_q;
    logic [7:0] last_byte_q;
    logic [7:0] pend_byte_q;
    logic [31:0] sent_cnt_q;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_go;
    logic slot_free;
    logic msg_done;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == wrhc_pkg::REG_CTRL) || (a == wrhc_pkg::REG_STATUS) ||
                 (a == wrhc_pkg::REG_LAST_BYTE) || (a == wrhc_pkg::REG_SENT_CNT);
    endfunction : mapped

    // Input synchronisers; pulled-up inputs rest high
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= wrhc_pkg::SYNC_RST;
            sync2_q <= wrhc_pkg::SYNC_RST;
        end else begin
            sync1_q <= {charged_n, tcut_n, oc_det, pwr_sig};
            sync2_q <= sync1_q;
        end
    end

    assign pwr_s = sync2_q[wrhc_pkg::SY_PWR];
    assign oc_s = sync2_q[wrhc_pkg::SY_OC];
    assign tcut_s_n = sync2_q[wrhc_pkg::SY_TCUT_N];
    assign charged_s_n = sync2_q[wrhc_pkg::SY_CHARGED_N];

    wrhc_spi_rx u_spi_rx (
        .clk(clk),
        .reset_n(reset_n),
        .spi_clk(spi_clk),
        .spi_rx(spi_rx),
        .byte_valid_q(rx_valid),
        .byte_q(rx_byte)
    );

    assign msg_done = msg_valid_q && msg_ack;
    assign slot_free = (slot_cnt_q == 32'h0) && !msg_valid_q;

    // Customer byte hand-off; extra bytes while busy are dropped
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            comms_flag_q <= 1'b1;
            pend_byte_q <= 8'h00;
            last_byte_q <= 8'h00;
            sent_cnt_q <= 32'h0;
        end else begin
            if (rx_valid && comms_flag_q) begin
                pend_byte_q <= rx_byte;
                last_byte_q <= rx_byte;
                comms_flag_q <= 1'b0;
            end else if (msg_done && msg_q.kind == wrhc_pkg::MSG_DATA) begin
                comms_flag_q <= 1'b1;
                sent_cnt_q <= sent_cnt_q + 32'h1;
            end
        end
    end

    // Slot pacing keeps customer traffic near four bytes a second
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            slot_cnt_q <= 32'h0;
        end else if (state_q != wrhc_pkg::ST_RUN) begin
            slot_cnt_q <= 32'h0;
        end else if (slot_free) begin
            slot_cnt_q <= SLOT_CYC - 32'h1;
        end else if (slot_cnt_q != 32'h0) begin
            slot_cnt_q <= slot_cnt_q - 32'h1;
        end
    end

    // Link sequence and message issue
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= wrhc_pkg::ST_OFF;
            msg_q <= '{kind: wrhc_pkg::MSG_NONE, data: 8'h00};
            msg_valid_q <= 1'b0;
            out_en_q <= 1'b0;
            err_code_q <= wrhc_pkg::ERR_NONE;
            retry_q <= 2'h0;
            pause_cnt_q <= 32'h0;
        end else begin
            if (msg_done) begin
                msg_valid_q <= 1'b0;
            end
            case (state_q)
                wrhc_pkg::ST_OFF: begin
                    out_en_q <= 1'b0;
                    msg_valid_q <= 1'b0;
                    if (pwr_s && ctrl_q[wrhc_pkg::CTRL_LINK_EN]) begin
                        state_q <= wrhc_pkg::ST_PING;
                    end
                end
                wrhc_pkg::ST_PING, wrhc_pkg::ST_IDCFG, wrhc_pkg::ST_XFER: begin
                    if (!pwr_s) begin
                        state_q <= wrhc_pkg::ST_OFF;
                    end else if (!msg_valid_q) begin
                        msg_valid_q <= 1'b1;
                        msg_q.data <= 8'h00;
                        if (state_q == wrhc_pkg::ST_PING) begin
                            msg_q.kind <= wrhc_pkg::MSG_PING;
                        end else if (state_q == wrhc_pkg::ST_IDCFG) begin
                            msg_q.kind <= wrhc_pkg::MSG_IDCFG;
                        end else begin
                            msg_q.kind <= wrhc_pkg::MSG_XFER;
                        end
                    end else if (msg_done) begin
                        if (state_q == wrhc_pkg::ST_PING) begin
                            state_q <= wrhc_pkg::ST_IDCFG;
                        end else if (state_q == wrhc_pkg::ST_IDCFG) begin
                            state_q <= wrhc_pkg::ST_XFER;
                        end else begin
                            state_q <= wrhc_pkg::ST_RUN;
                            out_en_q <= 1'b1;
                        end
                    end
                end
                wrhc_pkg::ST_RUN: begin
                    if (!pwr_s) begin
                        state_q <= wrhc_pkg::ST_OFF;
                    end else if (msg_done && msg_q.kind == wrhc_pkg::MSG_ERR &&
                                 msg_q.data[3:0] == wrhc_pkg::ERR_TCUT) begin
                        // Power cycle: drop output and wait out the pause; lock once retries reach RETRY_MAX
                        out_en_q <= 1'b0;
                        pause_cnt_q <= PAUSE_CYC - 32'h1;
                        if (retry_q == wrhc_pkg::RETRY_MAX[1:0]) begin
                            state_q <= wrhc_pkg::ST_LOCK;
                            err_code_q <= wrhc_pkg::ERR_TCUT;
                        end else begin
                            state_q <= wrhc_pkg::ST_CYCLE;
                            retry_q <= retry_q + 2'h1;
                        end
                    end else if (slot_free) begin
                        msg_valid_q <= 1'b1;
                        if (oc_s) begin
                            out_en_q <= 1'b0;
                            err_code_q <= wrhc_pkg::ERR_OC;
                            msg_q <= '{kind: wrhc_pkg::MSG_ERR, data: {4'h0, wrhc_pkg::ERR_OC}};
                        end else if (!tcut_s_n) begin
                            msg_q <= '{kind: wrhc_pkg::MSG_ERR,
                                       data: {4'h0, wrhc_pkg::ERR_TCUT}};
                        end else if (!charged_s_n) begin
                            msg_q <= '{kind: wrhc_pkg::MSG_DONE, data: 8'h00};
                        end else if (!comms_flag_q) begin
                            msg_q <= '{kind: wrhc_pkg::MSG_DATA, data: pend_byte_q};
                        end else begin
                            // Over-current recovery waits for the fault to clear
                            out_en_q <= 1'b1;
                            retry_q <= 2'h0;
                            err_code_q <= wrhc_pkg::ERR_NONE;
                            msg_q <= '{kind: wrhc_pkg::MSG_CTRL,
                                       data: ctrl_q[wrhc_pkg::CTRL_LEVEL_LSB +: 8]};
                        end
                    end
                end
                wrhc_pkg::ST_CYCLE: begin
                    msg_valid_q <= 1'b0;
                    if (pause_cnt_q == 32'h0) begin
                        state_q <= wrhc_pkg::ST_OFF;
                    end else begin
                        pause_cnt_q <= pause_cnt_q - 32'h1;
                    end
                end
                wrhc_pkg::ST_LOCK: begin
                    // Stays off until software clears it or reset
                    msg_valid_q <= 1'b0;
                    out_en_q <= 1'b0;
                    if (lock_clr_q) begin
                        state_q <= wrhc_pkg::ST_OFF;
                        retry_q <= 2'h0;
                        err_code_q <= wrhc_pkg::ERR_NONE;
                    end
                end
                default: begin
                    state_q <= wrhc_pkg::ST_OFF;
                end
            endcase
        end
    end

    // AXI write channel: address and data taken in either order
    assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= wrhc_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_addr_q) ? wrhc_pkg::RESP_OKAY : wrhc_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Control register with byte lanes; lock clear is a one-cycle pulse
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= wrhc_pkg::CTRL_RST;
            lock_clr_q <= 1'b0;
        end else begin
            lock_clr_q <= 1'b0;
            if (wr_go && aw_addr_q == wrhc_pkg::REG_CTRL) begin
                for (int i = 0; i < 4; i++) begin
                    if (w_strb_q[i]) begin
                        ctrl_q[i*8 +: 8] <= w_data_q[i*8 +: 8];
                    end
                end
                lock_clr_q <= w_strb_q[0] && w_data_q[wrhc_pkg::CTRL_LOCK_CLR];
                ctrl_q[wrhc_pkg::CTRL_LOCK_CLR] <= 1'b0;
            end
        end
    end

    // AXI read channel
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= wrhc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? wrhc_pkg::RESP_OKAY : wrhc_pkg::RESP_SLVERR;
            case (s_axi_araddr)
                wrhc_pkg::REG_CTRL: s_axi_rdata <= ctrl_q;
                wrhc_pkg::REG_STATUS: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rdata[wrhc_pkg::STAT_STATE_LSB +: 7] <= state_q;
                    s_axi_rdata[wrhc_pkg::STAT_FLAG] <= comms_flag_q;
                    s_axi_rdata[wrhc_pkg::STAT_RETRY_LSB +: 2] <= retry_q;
                    s_axi_rdata[wrhc_pkg::STAT_ERR_LSB +: 4] <= err_code_q;
                    s_axi_rdata[wrhc_pkg::STAT_PWR] <= pwr_s;
                    s_axi_rdata[wrhc_pkg::STAT_TCUT_N] <= tcut_s_n;
                    s_axi_rdata[wrhc_pkg::STAT_CHARGED_N] <= charged_s_n;
                    s_axi_rdata[wrhc_pkg::STAT_OUT_EN] <= out_en_q;
                end
                wrhc_pkg::REG_LAST_BYTE: s_axi_rdata <= {24'h0, last_byte_q};
                wrhc_pkg::REG_SENT_CNT: s_axi_rdata <= sent_cnt_q;
                default: s_axi_rdata <= 32'h0;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    flag_drop_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rx_valid && comms_flag_q) |=> (!comms_flag_q && pend_byte_q == $past(rx_byte)))
        else $error("flag did not fall after byte taken");

    flag_rise_a: assert property (@(posedge clk) disable iff (!reset_n)
        (msg_done && msg_q.kind == wrhc_pkg::MSG_DATA) |=> comms_flag_q)
        else $error("flag did not rise after byte sent");

    ping_reply_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == wrhc_pkg::ST_PING && pwr_s && !msg_valid_q)
        |=> (msg_valid_q && msg_q.kind == wrhc_pkg::MSG_PING))
        else $error("no ping reply to detection power");

    tcut_err_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == wrhc_pkg::ST_RUN && pwr_s && slot_free && !oc_s && !tcut_s_n)
        |=> (msg_q.kind == wrhc_pkg::MSG_ERR && msg_q.data[3:0] == wrhc_pkg::ERR_TCUT))
        else $error("thermal cutoff error not sent");

    lock_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == wrhc_pkg::ST_LOCK && !lock_clr_q)
        |=> (state_q == wrhc_pkg::ST_LOCK && err_code_q == wrhc_pkg::ERR_TCUT && !out_en_q))
        else $error("locked state left or output on");

    retry_bound_a: assert property (@(posedge clk) disable iff (!reset_n)
        retry_q <= wrhc_pkg::RETRY_MAX[1:0])
        else $error("too many power cycle retries");

    charged_msg_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == wrhc_pkg::ST_RUN && pwr_s && slot_free && !oc_s && tcut_s_n && !charged_s_n)
        |=> (msg_valid_q && msg_q.kind == wrhc_pkg::MSG_DONE))
        else $error("charge complete message not sent");

    oc_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == wrhc_pkg::ST_RUN && pwr_s && slot_free && oc_s)
        |=> (!out_en_q && msg_q.kind == wrhc_pkg::MSG_ERR && err_code_q == wrhc_pkg::ERR_OC))
        else $error("over-current not handled");

    msg_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        (msg_valid_q && !msg_ack && pwr_s && state_q == wrhc_pkg::ST_RUN)
        |=> (msg_valid_q && $stable(msg_q)))
        else $error("message changed before acknowledge");

    data_slot_a: assert property (@(posedge clk) disable iff (!reset_n)
        ($rose(msg_valid_q) && msg_q.kind == wrhc_pkg::MSG_DATA)
        |-> ($past(slot_cnt_q) == 32'h0 && $past(state_q) == wrhc_pkg::ST_RUN))
        else $error("customer byte sent outside a free slot");

endmodule : wrhc_core

// *** rtl/wrhc_pkg.sv ***
/*
 * Shared constants, types and register map of the wireless receiver host link.
 * Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package wrhc_pkg;

    // Clock and timing
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned SLOT_US = 250000;
    localparam int unsigned SLOT_CYC = SLOT_US * CLK_MHZ;
    localparam int unsigned PAUSE_MS = 500;
    localparam int unsigned PAUSE_CYC = PAUSE_MS * 1000 * CLK_MHZ;
    localparam int unsigned RETRY_MAX = 2;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_LAST_BYTE = 8'h08;
    localparam logic [7:0] REG_SENT_CNT = 8'h0C;

    // Control register fields and reset value
    localparam int CTRL_LINK_EN = 0;
    localparam int CTRL_LOCK_CLR = 1;
    localparam int CTRL_LEVEL_LSB = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_8001;

    // Status register fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_FLAG = 8;
    localparam int STAT_RETRY_LSB = 9;
    localparam int STAT_ERR_LSB = 12;
    localparam int STAT_PWR = 16;
    localparam int STAT_TCUT_N = 17;
    localparam int STAT_CHARGED_N = 18;
    localparam int STAT_OUT_EN = 19;

    // Synchroniser bit positions and their idle levels
    localparam int SY_PWR = 0;
    localparam int SY_OC = 1;
    localparam int SY_TCUT_N = 2;
    localparam int SY_CHARGED_N = 3;
    localparam logic [3:0] SYNC_RST = 4'hC;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Power-link message kinds
    typedef enum logic [3:0] {
        MSG_NONE = 4'h0,
        MSG_PING = 4'h1,
        MSG_IDCFG = 4'h2,
        MSG_XFER = 4'h3,
        MSG_CTRL = 4'h4,
        MSG_ERR = 4'h5,
        MSG_DONE = 4'h6,
        MSG_DATA = 4'h7
    } wrhc_kind_t;

    // Error codes
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_TCUT = 4'h1;
    localparam logic [3:0] ERR_OC = 4'h2;

    typedef struct packed {
        wrhc_kind_t kind;
        logic [7:0] data;
    } wrhc_msg_t;

    typedef enum logic [6:0] {
        ST_OFF = 7'h01,
        ST_PING = 7'h02,
        ST_IDCFG = 7'h04,
        ST_XFER = 7'h08,
        ST_RUN = 7'h10,
        ST_CYCLE = 7'h20,
        ST_LOCK = 7'h40
    } wrhc_state_t;

endpackage : wrhc_pkg

// *** rtl/wrhc_spi_rx.sv ***
/*
 * Receive-only two-wire serial byte catcher, clock and data from pins.
 * Assumes the host clock is far slower than clk, idle low, MSB first.
 */
`timescale 1ns/10ps
module wrhc_spi_rx (
    // System
    input wire logic clk,
    input wire logic reset_n,
    // Pins
    input wire logic spi_clk,
    input wire logic spi_rx,
    // Received byte
    output logic byte_valid_q,
    output logic [7:0] byte_q
);
    logic [1:0] sck_sync_q;
    logic [1:0] sdi_sync_q;
    logic sck_prev_q;
    logic [7:0] sh_q;
    logic [2:0] bit_cnt_q;
    logic fall;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sck_sync_q <= 2'h0;
            sdi_sync_q <= 2'h0;
            sck_prev_q <= 1'b0;
        end else begin
            sck_sync_q <= {sck_sync_q[0], spi_clk};
            sdi_sync_q <= {sdi_sync_q[0], spi_rx};
            sck_prev_q <= sck_sync_q[1];
        end
    end

    // Positive polarity, data taken on the second (falling) edge
    assign fall = sck_prev_q && !sck_sync_q[1];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sh_q <= 8'h00;
            bit_cnt_q <= 3'h0;
            byte_valid_q <= 1'b0;
            byte_q <= 8'h00;
        end else begin
            byte_valid_q <= 1'b0;
            if (fall) begin
                sh_q <= {sh_q[6:0], sdi_sync_q[1]};
                bit_cnt_q <= bit_cnt_q + 3'h1;
                if (bit_cnt_q == 3'h7) begin
                    byte_q <= {sh_q[6:0], sdi_sync_q[1]};
                    byte_valid_q <= 1'b1;
                end
            end
        end
    end

    byte_done_a: assert property (@(posedge clk) disable iff (!reset_n)
        (fall && bit_cnt_q == 3'h7) |=> (byte_valid_q && byte_q == $past({sh_q[6:0], sdi_sync_q[1]})))
        else $error("byte not delivered after eighth falling edge");

    msb_first_a: assert property (@(posedge clk) disable iff (!reset_n)
        fall |=> (sh_q[0] == $past(sdi_sync_q[1])))
        else $error("bit not shifted in at falling edge");

endmodule : wrhc_spi_rx

// *** test/wrhc_host_model.sv ***
/* Host model: bytes MSB first on a 160 ns serial clock, idle low.
   Assumes one go pulse per byte, only while the ready flag is high. */
`timescale 1ns/10ps
module wrhc_host_model (
    // Request
    input wire logic go,
    input wire logic [7:0] tx_byte,
    // Pins
    output logic spi_clk,
    output logic spi_rx
);
    initial begin
        {spi_clk, spi_rx} = 2'h0;
        forever begin
            @(posedge go);
            for (int i = 7; i >= 0; i--) begin
                spi_rx = tx_byte[i];
                #40 spi_clk = 1'b1;
                #80 spi_clk = 1'b0;
                #40;
            end
            // Released line must not keep a stale bit
            spi_rx = ~spi_rx;
        end
    end
endmodule : wrhc_host_model

// *** test/wrhc_core_tb_top.sv ***
/* Bench for the receiver core: host model on the byte link, random
   modulator acks, register bus task. Slot and pause counts shortened. */
`timescale 1ns/10ps
module wrhc_core_tb_top;
    logic clk, aw_r, w_r, b_v, ar_r, r_v, flag, mv, oe, sck, sdi;
    logic rst_n = 0, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0, go = 0, ack = 0;
    logic tc_n = 1, ch_n = 1, pwr = 0, oc = 0;
    logic [7:0] aa = 8'h0, tx = 8'h0, dq[$];
    logic [31:0] wd = 32'h0, rd, q;
    logic [3:0] ws = 4'h0, ec;
    logic [1:0] br, rr, rs;
    logic [15:0] seen = 16'h0;
    wrhc_pkg::wrhc_msg_t m;
    wrhc_pkg::wrhc_kind_t k0;
    int err_count = 0, total_checks = 0, cyc = 0, nerr = 0;
    wrhc_core #(.SLOT_CYC(200), .PAUSE_CYC(100)) i_wrhc_core (.clk(clk), .reset_n(rst_n),
        .s_axi_awaddr(aa), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(br),
        .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(aa), .s_axi_arvalid(ar_v),
        .s_axi_arready(ar_r), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(r_v),
        .s_axi_rready(r_r), .tcut_n(tc_n), .charged_n(ch_n), .spi_clk(sck), .spi_rx(sdi),
        .comms_flag_q(flag), .pwr_sig(pwr), .oc_det(oc), .msg_q(m), .msg_valid_q(mv),
        .msg_ack(ack), .out_en_q(oe), .err_code_q(ec));
    wrhc_host_model i_wrhc_host_model (.go(go), .tx_byte(tx), .spi_clk(sck), .spi_rx(sdi));
    task automatic chk(input logic ok, input string s);
        total_checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("mismatch at %0t: %s", $time, s);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        aa <= a;
        wd <= d;
        ws <= 4'hF;
        {aw_v, w_v, b_r} <= {3{wr}};
        {ar_v, r_r} <= {2{~wr}};
        do begin
            @(posedge clk);
            if (aw_r) aw_v <= 1'b0;
            if (w_r) w_v <= 1'b0;
            if (ar_r) ar_v <= 1'b0;
        end while (!(wr ? b_v : r_v));
        rs = wr ? br : rr;
        q = rd;
        {b_r, r_r} <= 2'h0;
    endtask : axi
    // Waits for the modulator to take a message of kind k
    task automatic wk(input wrhc_pkg::wrhc_kind_t k);
        seen = 16'h0;
        repeat (3000) if (!seen[k]) @(posedge clk);
        chk(seen[k], "message missing");
    endtask : wk
    always @(posedge clk) begin
        cyc++;
        ack <= 1'($urandom & 1);
        if (mv && ack) begin
            if (seen == 16'h0) k0 = m.kind;
            seen[m.kind] = 1'b1;
            nerr += int'(m.kind == wrhc_pkg::MSG_ERR);
            if (m.kind == wrhc_pkg::MSG_DATA) begin
                chk(flag === 1'b0, "flag high with byte pending");
                chk(dq.size() > 0 && m.data === dq.pop_front(), "byte value");
            end
            if (m.kind == wrhc_pkg::MSG_CTRL)
                chk(m.data === wrhc_pkg::CTRL_RST[wrhc_pkg::CTRL_LEVEL_LSB +: 8], "level");
        end
        if (cyc == 20000) begin
            chk(1'b0, "timeout");
            tally_and_finish();
        end
    end
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        void'($urandom(89));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk(flag === 1'b1 && oe === 1'b0 && mv === 1'b0, "reset state");
        pwr <= 1'b1;
        wk(wrhc_pkg::MSG_XFER);
        chk(k0 === wrhc_pkg::MSG_PING, "ping not first");
        repeat (3) begin
            wait (flag === 1'b1);
            @(posedge clk);
            tx <= 8'($urandom);
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            dq.push_back(tx);
            wk(wrhc_pkg::MSG_DATA);
            repeat (2) @(posedge clk);
            chk(flag === 1'b1, "flag not back");
        end
        axi(1'b0, wrhc_pkg::REG_SENT_CNT, 32'h0);
        chk(rs === wrhc_pkg::RESP_OKAY && q === 32'h3, "sent count");
        axi(1'b0, wrhc_pkg::REG_LAST_BYTE, 32'h0);
        chk(q === {24'h0, tx}, "last byte");
        ch_n <= 1'b0;
        wk(wrhc_pkg::MSG_DONE);
        ch_n <= 1'b1;
        nerr = 0;
        tc_n <= 1'b0;
        repeat (8000) if (ec !== wrhc_pkg::ERR_TCUT) @(posedge clk);
        repeat (300) @(posedge clk);
        chk(nerr === 3 && oe === 1'b0 && ec === wrhc_pkg::ERR_TCUT, "lockout");
        axi(1'b0, wrhc_pkg::REG_STATUS, 32'h0);
        chk(rs === wrhc_pkg::RESP_OKAY && q[6:0] === wrhc_pkg::ST_LOCK, "status");
        axi(1'b0, 8'h10, 32'h0);
        chk(rs === wrhc_pkg::RESP_SLVERR && q === 32'h0, "unmapped read");
        tc_n <= 1'b1;
        axi(1'b1, wrhc_pkg::REG_CTRL, 32'h0000_8003);
        chk(rs === wrhc_pkg::RESP_OKAY, "lock clear");
        wk(wrhc_pkg::MSG_PING);
        wk(wrhc_pkg::MSG_XFER);
        // Fault held across a slot, then released
        oc <= 1'b1;
        wk(wrhc_pkg::MSG_ERR);
        chk(oe === 1'b0 && ec === wrhc_pkg::ERR_OC, "over-current");
        oc <= 1'b0;
        wk(wrhc_pkg::MSG_CTRL);
        chk(oe === 1'b1 && ec === wrhc_pkg::ERR_NONE, "over-current recovery");
        pwr <= 1'b0;
        repeat (20) @(posedge clk);
        chk(mv === 1'b0 && oe === 1'b0, "power removed");
        tally_and_finish();
    end
endmodule : wrhc_core_tb_top
